/* File: hdl/asr_ctrl.sv */
`timescale 1ns/100ps
// Operation
// RL1: write only while strobe and both selects active
// RL2: data timing measured from write-ending edge
// RL3: data stable 25 ns before write end
// RL4: address held across whole write
// RL5: 35 ns address, select and strobe
// RL6: read data valid 45 ns after address
// RL7: old read data held 10 ns
// RL8: data valid 22 ns after output enable
// RL9: output enable high keeps pins released
// RL10: select drop with strobe keeps pins released
// RL11: never drive pins while memory drives
// RL12: write strobe high through every read
// RL13: selects always driven to definite levels
// RL14: address valid no later than selects
// RL15: memory drives only selected reading
// RL16: selected strobe low stores the byte
// RL17: memory releases pins otherwise
// RL18: twenty address lines, eight data bits
// RL19: cycle time kept, waits timed by counters
module asr_ctrl #(
   parameter int ADDR_W = asr_pkg::ADDR_W,
   parameter int DATA_W = asr_pkg::DATA_W
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   output logic req_ready,
   output logic rsp_valid,
   output logic [DATA_W-1:0] rsp_rdata,
   output logic [ADDR_W-1:0] mem_addr,
   output logic select_low_active_n,
   output logic select_high_active,
   output logic mem_we_n,
   output logic mem_oe_n,
   output logic [DATA_W-1:0] mem_dq_out,
   output logic mem_dq_oe,
   input wire logic [DATA_W-1:0] mem_dq_in
);
   import asr_pkg::*;

   // geometry is fixed: reset values and the timer sizing assume it
   if (ADDR_W != 20 || DATA_W != 8) begin : g_geom_chk
      $error("asr_ctrl needs 20x8"); // RL18
   end

   typedef struct packed {
      asr_state_t st;
      logic [CNT_W-1:0] cyc;
      logic ready;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [ADDR_W-1:0] addr;
      logic ce_n;
      logic ce;
      logic we_n;
      logic oe_n;
      logic [DATA_W-1:0] dout;
      logic doe;
   } asr_ctl_t;
   asr_ctl_t q_r, q_nxt;

   logic t_load;
   logic [CNT_W-1:0] t_count;
   logic t_done;

   ////////////////////////////////////////////////////////////////////
   // wait timer for strobe and access phases
   asr_timer #(.W(CNT_W)) u_tmr (
      .clk(clk),
      .rst(rst),
      .load(t_load),
      .count(t_count),
      .done(t_done)
   );

   ////////////////////////////////////////////////////////////////////
   // access sequencer
   always_comb begin
      q_nxt = q_r;
      q_nxt.rvalid = 1'b0;
      t_load = 1'b0;
      t_count = '0;
      if (q_r.cyc != '0) begin
         q_nxt.cyc = q_r.cyc - 1'b1; // RL19
      end
      case (q_r.st)
         ASR_IDLE: begin
            if (req_valid && q_r.ready) begin
               q_nxt.ready = 1'b0;
               // address first, selects follow a cycle later
               q_nxt.addr = req_addr; // RL14
               if (req_write) begin
                  q_nxt.cyc = CNT_W'(WC_CYC); // RL19
                  q_nxt.dout = req_wdata;
                  q_nxt.st = ASR_WSTRB;
               end else begin
                  q_nxt.cyc = CNT_W'(RC_CYC); // RL19
                  q_nxt.st = ASR_RSEL;
               end
            end
         end
         ASR_RSEL: begin
            // strobe stays high, output enable with selects
            q_nxt.ce_n = 1'b0;
            q_nxt.ce = 1'b1;
            q_nxt.oe_n = 1'b0;
            q_nxt.we_n = 1'b1; // RL12
            t_load = 1'b1;
            t_count = CNT_W'(AA_CYC > DOE_CYC ? AA_CYC : DOE_CYC); // RL6 RL8
            q_nxt.st = ASR_RWAIT;
         end
         ASR_RWAIT: begin
            if (t_done) begin
               // sample before address or selects move
               q_nxt.rdata = mem_dq_in; // RL7
               q_nxt.rvalid = 1'b1;
               q_nxt.ce_n = 1'b1;
               q_nxt.ce = 1'b0;
               q_nxt.oe_n = 1'b1;
               t_load = 1'b1;
               t_count = CNT_W'(HZ_CYC);
               q_nxt.st = ASR_TURN;
            end
         end
         ASR_WSTRB: begin
            // oe stays high so the memory never drives during a write
            q_nxt.oe_n = 1'b1; // RL9 RL11
            q_nxt.ce_n = 1'b0;
            q_nxt.ce = 1'b1;
            q_nxt.we_n = 1'b0; // RL1
            q_nxt.doe = 1'b1;
            t_load = 1'b1;
            t_count = CNT_W'(PWE_CYC > SD_CYC ? PWE_CYC : SD_CYC); // RL3 RL5
            q_nxt.st = ASR_WEND;
         end
         ASR_WEND: begin
            if (t_done) begin
               // strobe and selects end together; address, data stay a cycle
               q_nxt.we_n = 1'b1; // RL2 RL10
               q_nxt.ce_n = 1'b1;
               q_nxt.ce = 1'b0;
               q_nxt.st = ASR_GAP;
            end
         end
         ASR_TURN: begin
            // let the memory release the bus before anything else
            if (t_done) begin
               q_nxt.st = ASR_GAP; // RL11
            end
         end
         ASR_GAP: begin
            q_nxt.doe = 1'b0; // RL4
            if (q_r.cyc <= CNT_W'(1)) begin
               q_nxt.ready = 1'b1; // RL19
               q_nxt.st = ASR_IDLE;
            end
         end
         default: begin
            q_nxt.st = ASR_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   // state register; selects reset to a definite deselect
   always_ff @(posedge clk) begin
      if (rst) begin
         q_r.st <= ASR_IDLE;
         q_r.cyc <= '0;
         q_r.ready <= 1'b1;
         q_r.rvalid <= 1'b0;
         q_r.rdata <= DATA_RST;
         q_r.addr <= ADDR_RST;
         q_r.ce_n <= 1'b1; // RL13
         q_r.ce <= 1'b0;
         q_r.we_n <= 1'b1;
         q_r.oe_n <= 1'b1;
         q_r.dout <= DATA_RST;
         q_r.doe <= 1'b0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign req_ready = q_r.ready;
   assign rsp_valid = q_r.rvalid;
   assign rsp_rdata = q_r.rdata;
   assign mem_addr = q_r.addr;
   assign select_low_active_n = q_r.ce_n;
   assign select_high_active = q_r.ce;
   assign mem_we_n = q_r.we_n;
   assign mem_oe_n = q_r.oe_n;
   assign mem_dq_out = q_r.dout;
   assign mem_dq_oe = q_r.doe;

   ////////////////////////////////////////////////////////////////////
   // checks
   chk_no_contention: assert property (@(posedge clk) disable iff (rst) // RL11
      !(mem_dq_oe && !mem_oe_n))
      else $error("controller and memory drive together");
   chk_read_we_high: assert property (@(posedge clk) disable iff (rst) // RL12
      (!mem_oe_n && !select_low_active_n) |-> mem_we_n)
      else $error("write strobe low during read");
   chk_sel_pair: assert property (@(posedge clk) disable iff (rst) // RL13
      select_low_active_n == !select_high_active)
      else $error("selects disagree");
   chk_wr_pulse_len: assert property (@(posedge clk) disable iff (rst) // RL5
      $fell(mem_we_n) |-> !mem_we_n [*4])
      else $error("write strobe too short");
   chk_wr_addr_hold: assert property (@(posedge clk) disable iff (rst) // RL4
      !mem_we_n |=> $stable(mem_addr) && $stable(mem_dq_out))
      else $error("address or data moved in write");
   chk_wr_data_on: assert property (@(posedge clk) disable iff (rst) // RL1
      !mem_we_n |-> mem_dq_oe && !select_low_active_n)
      else $error("write without data or select");
   chk_rd_addr_first: assert property (@(posedge clk) disable iff (rst) // RL14
      $fell(select_low_active_n) |-> $stable(mem_addr))
      else $error("address moved with select");
   chk_cycle_gap: assert property (@(posedge clk) disable iff (rst) // RL19
      (req_valid && req_ready) |=> !req_ready [*4])
      else $error("access started before cycle time");
   chk_rd_wait: assert property (@(posedge clk) disable iff (rst) // RL6
      $fell(mem_oe_n) |-> !mem_oe_n [*5])
      else $error("read sampled too early");
endmodule

/* File: hdl/asr_pkg.sv */
package asr_pkg;
   // memory geometry
   localparam int ADDR_W = 20;
   localparam int DATA_W = 8;
   // clock period in ns
   localparam int CLK_NS = 10;
   // pin timing in ns
   localparam int T_RC_NS = 45;
   localparam int T_WC_NS = 45;
   localparam int T_AA_NS = 45;
   localparam int T_DOE_NS = 22;
   localparam int T_PWE_NS = 35;
   localparam int T_SD_NS = 25;
   localparam int T_HZOE_NS = 18;
   // cycle counts: least times round up, longest times too (wait covers max)
   localparam int RC_CYC = (T_RC_NS + CLK_NS - 1) / CLK_NS;
   localparam int WC_CYC = (T_WC_NS + CLK_NS - 1) / CLK_NS;
   localparam int AA_CYC = (T_AA_NS + CLK_NS - 1) / CLK_NS;
   localparam int DOE_CYC = (T_DOE_NS + CLK_NS - 1) / CLK_NS;
   localparam int PWE_CYC = (T_PWE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SD_CYC = (T_SD_NS + CLK_NS - 1) / CLK_NS;
   localparam int HZ_CYC = (T_HZOE_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W = 4;
   // values after reset
   localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

   typedef enum logic [2:0] {
      ASR_IDLE = 3'b000,
      ASR_RSEL = 3'b001,
      ASR_RWAIT = 3'b010,
      ASR_WSTRB = 3'b011,
      ASR_WEND = 3'b100,
      ASR_TURN = 3'b101,
      ASR_GAP = 3'b110
   } asr_state_t;
endpackage

/* File: hdl/asr_timer.sv */
`timescale 1ns/100ps
// down counter that flags when a programmed wait has run out
module asr_timer #(
   parameter int W = 4
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic load,
   input wire logic [W-1:0] count,
   output logic done
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic done;
   } asr_tmr_t;
   asr_tmr_t q_r, q_nxt;

   // a one-bit counter cannot hold the longest wait
   if (W < 2) begin : g_w_chk
      $error("asr_timer width too small");
   end

   // load wins over counting; done rises as the count steps from one to zero
   always_comb begin
      q_nxt = q_r;
      q_nxt.done = 1'b0;
      if (load) begin
         q_nxt.cnt = count;
      end else if (q_r.cnt != '0) begin
         q_nxt.cnt = q_r.cnt - 1'b1;
         q_nxt.done = (q_r.cnt == W'(1));
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign done = q_r.done;
endmodule

/* File: verification/asr_sram_model.sv */
`timescale 1ns/100ps
// behavioural byte-wide static memory facing the port
module asr_sram_model #(
   parameter int DLY = asr_pkg::T_AA_NS,
   parameter int HOLD = 10
) (
   input wire logic [asr_pkg::ADDR_W-1:0] mem_addr,
   input wire logic select_low_active_n,
   input wire logic select_high_active,
   input wire logic mem_we_n,
   input wire logic mem_oe_n,
   input wire logic [asr_pkg::DATA_W-1:0] mem_dq_out,
   input wire logic mem_dq_oe,
   output logic [asr_pkg::DATA_W-1:0] mem_dq_in
);
   import asr_pkg::*;
   logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
   logic [DATA_W-1:0] q = 8'h00;
   logic sel;
   logic rd;
   ////////////////////////////////////////////////////////////////////
   // both selects must agree; reads only with strobe high
   assign sel = !select_low_active_n && select_high_active;
   assign rd = sel && !mem_oe_n && mem_we_n;
   // store while strobe and selects overlap; any one ends it
   always @(sel, mem_we_n, mem_addr, mem_dq_out) begin
      if (sel && !mem_we_n) begin
         mem[mem_addr] = mem_dq_out;
      end
   end
   // lagged output: old byte held, unknown in between, new one at the
   // latest time, so an early sample never matches by luck
   always @(mem_addr, rd) begin
      q <= #(HOLD) 8'hXX;
      q <= #(DLY) mem[mem_addr];
   end
   // released pins show the inverse, so stale reads never match
   assign mem_dq_in = mem_dq_oe ? (rd ? 8'hXX : mem_dq_out)
                                : (rd ? q : ~q);
endmodule

/* File: verification/async_sram_1mx8_port_test.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
$display("BAD %0t got %h want %h", $time, a, e); end end
module async_sram_1mx8_port_test;
   import asr_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic [ADDR_W-1:0] req_addr = 20'h00000;
   logic [DATA_W-1:0] req_wdata = 8'h00;
   logic req_ready, rsp_valid, select_low_active_n, select_high_active;
   logic mem_we_n, mem_oe_n, mem_dq_oe;
   logic [DATA_W-1:0] rsp_rdata, mem_dq_out, mem_dq_in;
   logic [ADDR_W-1:0] mem_addr, w_addr;
   logic [DATA_W-1:0] w_data;
   logic [DATA_W-1:0] ref_mem [int];
   int bad_count = 0;
   int cmp_count = 0;
   int lo_cnt = 0;
   asr_ctrl i_dut (.clk, .rst, .req_valid, .req_write, .req_addr,
      .req_wdata, .req_ready, .rsp_valid, .rsp_rdata, .mem_addr,
      .select_low_active_n, .select_high_active, .mem_we_n, .mem_oe_n,
      .mem_dq_out, .mem_dq_oe, .mem_dq_in);
   asr_sram_model i_mem (.mem_addr, .select_low_active_n,
      .select_high_active, .mem_we_n, .mem_oe_n, .mem_dq_out, .mem_dq_oe,
      .mem_dq_in);
   ////////////////////////////////////////////////////////////////////
   // 100 MHz clock
   initial begin
      forever #5 clk = ~clk;
   end
   // pin discipline, judged on values settled before each edge
   always @(posedge clk) begin
      if (!rst) begin
         `CHK(select_low_active_n ^ select_high_active, 1'b1)
         if (!mem_oe_n) `CHK(mem_we_n, 1'b1)
         if (mem_dq_oe) `CHK(mem_oe_n, 1'b1)
         if (!mem_we_n) begin
            lo_cnt <= lo_cnt + 1;
            `CHK(select_high_active, 1'b1)
            if (lo_cnt == 0) begin
               w_addr <= mem_addr;
               w_data <= mem_dq_out;
            end else begin
               `CHK(mem_dq_out, w_data)
            end
         end else if (lo_cnt != 0) begin
            `CHK(lo_cnt >= PWE_CYC, 1'b1)
            lo_cnt <= 0;
         end
         if (lo_cnt != 0) `CHK(mem_addr, w_addr)
      end
   end
   ////////////////////////////////////////////////////////////////////
   task automatic results();
      if (bad_count == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // hold the request until the port takes it; refused edges ignored
   task automatic issue(input logic w, input logic [ADDR_W-1:0] a,
         input logic [DATA_W-1:0] d);
      int n;
      n = 0;
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= a;
      req_wdata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (req_ready !== 1'b1 && n < 50);
      if (req_ready !== 1'b1) begin
         bad_count++;
         results();
      end
      req_valid <= 1'b0;
      // let an edge pass so a following call never reassigns in this step
      @(posedge clk);
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
      issue(1'b1, a, d);
      ref_mem[a] = d;
   endtask
   task automatic rd(input logic [ADDR_W-1:0] a);
      int n;
      n = 0;
      issue(1'b0, a, 8'hA5);
      do begin
         @(posedge clk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 20);
      if (rsp_valid !== 1'b1) begin
         bad_count++;
         results();
      end
      `CHK(rsp_rdata, ref_mem[a])
   endtask
   ////////////////////////////////////////////////////////////////////
   // reset, edges of the address space, then a random mix
   initial begin
      logic [ADDR_W-1:0] a;
      void'($urandom(99812));
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      `CHK({req_ready, mem_we_n, mem_oe_n, mem_dq_oe}, 4'hE)
      `CHK(select_low_active_n, 1'b1)
      wr(20'h00000, 8'h5A);
      wr(20'hFFFFF, 8'hC3);
      rd(20'hFFFFF);
      rd(20'h00000);
      for (int i = 0; i < 60; i++) begin
         a = {($urandom % 2) ? 16'hFFFF : 16'h0000, 4'($urandom)};
         if ($urandom % 2 || !ref_mem.exists(a)) begin
            wr(a, 8'($urandom));
         end else begin
            rd(a);
         end
      end
      results();
   end
endmodule
